//--- design/csu_pkg.sv
// Purpose: Constants and types for the chip-select and wait-state unit
// Assumes: 20-bit memory address, 16-bit I/O address, 100 MHz clock
// Notes: Address fields are held as upper address bits only
package csu_pkg;
  // Bus phase sequencer, Gray along T1..T3, wait, T4
  typedef enum logic [2:0]
  {
    CSU_IDLE = 3'h0,
    CSU_T1 = 3'h1,
    CSU_T2 = 3'h3,
    CSU_T3 = 3'h2,
    CSU_TW = 3'h6,
    CSU_T4 = 3'h7
  } csu_phase_t;

  // Wait sub-phase while in the wait state
  typedef enum logic [1:0]
  {
    CSU_W_PROG = 2'h0,
    CSU_W_HOLD = 2'h1,
    CSU_W_EXTRA = 2'h3
  } csu_wait_t;

  localparam int CSU_AW = 20; // Memory address width
  localparam int CSU_WW = 4; // Merged wait count width
  localparam int CSU_NMID = 4; // Midrange selects
  localparam int CSU_NPER = 7; // Peripheral select slots
  localparam int CSU_PER_UNPINNED = 4; // Slot without a pin
  localparam int CSU_PER_UP_LO = 5; // First upper peripheral slot

  // Upper select reset defaults: top 64K, ready, three waits
  localparam logic [9:0] CSU_UPPER_BASE_RST = 10'h03c0;
  localparam logic CSU_UPPER_READY_RST = 1'b1;
  localparam logic [1:0] CSU_UPPER_WAIT_RST = 2'h3;
  localparam logic CSU_UPPER_DA_RST = 1'b0;
  localparam logic [9:0] CSU_UPPER_TOP = 10'h03ff; // Always ends at top

  // Midrange block is 8K times two to the size code
  localparam int CSU_MID_SHIFT0 = 11; // Quarter of smallest block
  localparam logic [2:0] CSU_MID_CODE_MAX = 3'h6;

  // Three-bit lower peripheral wait codes 4..7
  localparam logic [3:0] CSU_WAIT_C4 = 4'h5;
  localparam logic [3:0] CSU_WAIT_C5 = 4'h7;
  localparam logic [3:0] CSU_WAIT_C6 = 4'h9;
  localparam logic [3:0] CSU_WAIT_C7 = 4'hf;
endpackage : csu_pkg

//--- design/csu_chip_select.sv
// Purpose: Chip-select decode, ready sensing and wait-state insertion
// Assumes: One bus cycle at a time; config words loaded by strobes
// Notes: Select outputs are active low and held from T1 through T4
//
// What this block does
// - Selects assert for CPU and DMA cycles
// - Provide latched low word-address bits
// - Upper, lower selects assert with address
// - Either async or sync ready accepted
// - Each external region has ready-required bit
// - Internal RAM: no ready, zero waits
// - Two-bit wait for most selects
// - Lower peripherals: three-bit wait, 5/7/9/15
// - Programmed waits finish before ready acts
// - Ready sampled first wait; ends on time
// - Late ready: hold, one extra wait
// - Peripheral block, RAM act as zero-wait selects
// - Address drive disabled for upper/lower selects
// - Enabled ready/wait logic survives PIO mode
// - Unpinned peripheral slot keeps wait logic
// - Latched-address mode drops upper peripheral waits
// - Mismatched overlap may stall on ready
// - Overlap only within the same space
// - Upper select reset: top 64K, ready, three
// - Each peripheral select spans 256 bytes
`timescale 1ns/1ps
`default_nettype none
module csu_chip_select
  import csu_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  // Cycle requests from the CPU and DMA engines
  input wire logic cpu_cycle_start,
  input wire logic [19:0] cpu_addr,
  input wire logic cpu_is_io,
  input wire logic dma_cycle_start,
  input wire logic [19:0] dma_addr,
  input wire logic dma_is_io,
  // Ready pins from the outside world
  input wire logic async_ready_input,
  input wire logic sync_ready_input,
  // Upper select configuration
  input wire logic upper_cfg_load,
  input wire logic [9:0] upper_cfg_base,
  input wire logic upper_cfg_ready,
  input wire logic [1:0] upper_cfg_wait,
  input wire logic upper_cfg_da,
  // Lower select configuration
  input wire logic lower_cfg_load,
  input wire logic [9:0] lower_cfg_top,
  input wire logic lower_cfg_ready,
  input wire logic [1:0] lower_cfg_wait,
  input wire logic lower_cfg_da,
  // Midrange select configuration
  input wire logic mid_cfg_load,
  input wire logic [6:0] mid_cfg_base,
  input wire logic mid_cfg_ready,
  input wire logic [1:0] mid_cfg_wait,
  // Peripheral block base configuration
  input wire logic pbase_cfg_load,
  input wire logic [8:0] pbase_cfg_base,
  input wire logic pbase_cfg_ready,
  input wire logic [2:0] pbase_cfg_wait,
  // Midrange size and peripheral mode configuration
  input wire logic msize_cfg_load,
  input wire logic [2:0] msize_cfg_code,
  input wire logic msize_cfg_io,
  input wire logic msize_cfg_latch_addr,
  input wire logic msize_cfg_ready,
  input wire logic [1:0] msize_cfg_wait,
  // Internal RAM and internal peripheral block mapping
  input wire logic iram_enable,
  input wire logic [4:0] iram_base,
  input wire logic [11:0] pcb_base,
  input wire logic pcb_in_mem,
  // Select pins, active low
  output logic upper_mem_select_n,
  output logic lower_mem_select_n,
  output logic [3:0] midrange_selects_n,
  output logic [1:0] upper_periph_selects_n,
  output logic [3:0] lower_periph_selects_n,
  // Status toward the bus unit
  output logic [1:0] latched_addr_bits,
  output logic address_drive_disable,
  output logic iram_hit,
  output logic pcb_hit,
  output csu_phase_t bus_phase,
  output logic waiting_ready,
  output logic cycle_done
);

  // Two-stage synchronisers for both ready pins
  logic [1:0] async_ready_input_sync_r;
  logic [1:0] sync_ready_input_sync_r;
  logic ready_ok; // Either ready input seen

  // Configuration state
  logic [9:0] up_base_r;
  logic up_ready_r;
  logic [1:0] up_wait_r;
  logic up_da_r;
  logic lo_en_r;
  logic [9:0] lo_top_r;
  logic lo_ready_r;
  logic [1:0] lo_wait_r;
  logic lo_da_r;
  logic mid_wr_r; // Midrange config written
  logic [6:0] mid_base_r;
  logic mid_ready_r;
  logic [1:0] mid_wait_r;
  logic pb_wr_r; // Peripheral base written
  logic [8:0] pb_base_r;
  logic pb_ready_r;
  logic [2:0] pb_wait_r;
  logic ms_wr_r; // Size/mode register written
  logic [2:0] ms_code_r;
  logic ms_io_r;
  logic ms_latch_r;
  logic ms_ready_r;
  logic [1:0] ms_wait_r;

  // Current request, from whichever engine started it
  logic start;
  logic [19:0] addr;
  logic is_io;

  // Decode results for the current request
  logic hit_up;
  logic hit_lo;
  logic hit_mid;
  logic [1:0] mid_idx;
  logic hit_per;
  logic [2:0] per_idx;
  logic hit_iram;
  logic hit_pcb;
  logic [19:0] mid_off;
  logic mer_ready; // Merged ready requirement
  logic [3:0] mer_wait; // Merged wait count
  logic [3:0] pb_wait4; // Expanded three-bit code

  // Cycle state
  csu_phase_t phase_r;
  csu_wait_t wsub_r;
  logic [3:0] wcnt_r;
  logic need_rdy_r;
  logic first_w_r;
  logic rdy_seen_r;
  logic sel_up_r;
  logic sel_lo_r;
  logic [3:0] sel_mid_r;
  logic [6:0] sel_per_r;
  logic [1:0] a21_r;
  logic iram_r;
  logic pcb_r;

  // Ready pins come from outside, so sync before use
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      async_ready_input_sync_r <= 2'h0;
      sync_ready_input_sync_r <= 2'h0;
    end
    else
    begin
      async_ready_input_sync_r <= {async_ready_input_sync_r[0], async_ready_input};
      sync_ready_input_sync_r <= {sync_ready_input_sync_r[0], sync_ready_input};
    end
  end

  // Either ready source ends the wait
  assign ready_ok = async_ready_input_sync_r[1] | sync_ready_input_sync_r[1];

  // Upper and lower select configuration
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      up_base_r <= CSU_UPPER_BASE_RST;
      up_ready_r <= CSU_UPPER_READY_RST;
      up_wait_r <= CSU_UPPER_WAIT_RST;
      up_da_r <= CSU_UPPER_DA_RST;
      lo_en_r <= 1'b0;
      lo_top_r <= 10'h000;
      lo_ready_r <= 1'b0;
      lo_wait_r <= 2'h0;
      lo_da_r <= 1'b0;
    end
    else
    begin
      if (upper_cfg_load)
      begin
        up_base_r <= upper_cfg_base;
        up_ready_r <= upper_cfg_ready;
        up_wait_r <= upper_cfg_wait;
        up_da_r <= upper_cfg_da;
      end
      if (lower_cfg_load)
      begin
        lo_en_r <= 1'b1;
        lo_top_r <= lower_cfg_top;
        lo_ready_r <= lower_cfg_ready;
        lo_wait_r <= lower_cfg_wait;
        lo_da_r <= lower_cfg_da;
      end
    end
  end

  // Midrange and peripheral configuration; enables need both writes
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mid_wr_r <= 1'b0;
      mid_base_r <= 7'h00;
      mid_ready_r <= 1'b0;
      mid_wait_r <= 2'h0;
      pb_wr_r <= 1'b0;
      pb_base_r <= 9'h000;
      pb_ready_r <= 1'b0;
      pb_wait_r <= 3'h0;
      ms_wr_r <= 1'b0;
      ms_code_r <= 3'h0;
      ms_io_r <= 1'b0;
      ms_latch_r <= 1'b0;
      ms_ready_r <= 1'b0;
      ms_wait_r <= 2'h0;
    end
    else
    begin
      if (mid_cfg_load)
      begin
        mid_wr_r <= 1'b1;
        mid_base_r <= mid_cfg_base;
        mid_ready_r <= mid_cfg_ready;
        mid_wait_r <= mid_cfg_wait;
      end
      if (pbase_cfg_load)
      begin
        pb_wr_r <= 1'b1;
        pb_base_r <= pbase_cfg_base;
        pb_ready_r <= pbase_cfg_ready;
        pb_wait_r <= pbase_cfg_wait;
      end
      if (msize_cfg_load)
      begin
        ms_wr_r <= 1'b1;
        // Oversized codes clamp to the largest block
        ms_code_r <= (msize_cfg_code > CSU_MID_CODE_MAX) ?
          CSU_MID_CODE_MAX : msize_cfg_code;
        ms_io_r <= msize_cfg_io;
        ms_latch_r <= msize_cfg_latch_addr;
        ms_ready_r <= msize_cfg_ready;
        ms_wait_r <= msize_cfg_wait;
      end
    end
  end

  // CPU and DMA cycles share the decode; CPU wins a same-cycle tie
  assign start = cpu_cycle_start | dma_cycle_start;
  assign addr = cpu_cycle_start ? cpu_addr : dma_addr;
  assign is_io = cpu_cycle_start ? cpu_is_io : dma_is_io;
  assign mid_off = addr - {mid_base_r, 13'h0000};

  // Region decode; memory regions never match I/O cycles
  always_comb
  begin
    hit_up = !is_io && addr[19:10] >= up_base_r;
    hit_lo = !is_io && lo_en_r && addr[19:10] <= lo_top_r;
    // Enable follows the writes, not the pin function
    hit_mid = !is_io && mid_wr_r && ms_wr_r
      && (mid_off >> (CSU_MID_SHIFT0 + 2 + ms_code_r)) == 20'h0_0000;
    mid_idx = 2'(mid_off >> (CSU_MID_SHIFT0 + ms_code_r));
    hit_per = pb_wr_r && ms_wr_r && (ms_io_r == is_io)
      && addr[19:11] == pb_base_r;
    per_idx = addr[10:8];
    hit_iram = !is_io && iram_enable && addr[19:15] == iram_base;
    hit_pcb = (pcb_in_mem != is_io) && addr[19:8] == pcb_base;
  end

  // Lower peripheral three-bit code expansion
  always_comb
  begin
    unique case (pb_wait_r)
      3'h4: pb_wait4 = CSU_WAIT_C4;
      3'h5: pb_wait4 = CSU_WAIT_C5;
      3'h6: pb_wait4 = CSU_WAIT_C6;
      3'h7: pb_wait4 = CSU_WAIT_C7;
      default: pb_wait4 = {1'b0, pb_wait_r};
    endcase
  end

  // Merge all external hits: worst wait and any ready demand.
  // Mismatched overlap is a software fault; merging can stall.
  always_comb
  begin
    mer_ready = 1'b0;
    mer_wait = 4'h0;
    if (hit_up)
    begin
      mer_ready = mer_ready | up_ready_r;
      mer_wait = (mer_wait > {2'h0, up_wait_r}) ?
        mer_wait : {2'h0, up_wait_r};
    end
    if (hit_lo)
    begin
      mer_ready = mer_ready | lo_ready_r;
      mer_wait = (mer_wait > {2'h0, lo_wait_r}) ?
        mer_wait : {2'h0, lo_wait_r};
    end
    if (hit_mid)
    begin
      mer_ready = mer_ready | mid_ready_r;
      mer_wait = (mer_wait > {2'h0, mid_wait_r}) ?
        mer_wait : {2'h0, mid_wait_r};
    end
    // Slots 0..4 (unpinned one included) use the three-bit code
    if (hit_per && per_idx <= 3'(CSU_PER_UNPINNED))
    begin
      mer_ready = mer_ready | pb_ready_r;
      mer_wait = (mer_wait > pb_wait4) ? mer_wait : pb_wait4;
    end
    // Upper slots lose waits in latched-address mode
    if (hit_per && per_idx >= 3'(CSU_PER_UP_LO) && per_idx
      < 3'(CSU_NPER) && !ms_latch_r)
    begin
      mer_ready = mer_ready | ms_ready_r;
      mer_wait = (mer_wait > {2'h0, ms_wait_r}) ?
        mer_wait : {2'h0, ms_wait_r};
    end
    // Internal RAM and peripheral block add zero and no ready
  end

  // Capture selects and latched address at cycle start
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sel_up_r <= 1'b0;
      sel_lo_r <= 1'b0;
      sel_mid_r <= 4'h0;
      sel_per_r <= 7'h00;
      a21_r <= 2'h0;
      iram_r <= 1'b0;
      pcb_r <= 1'b0;
      need_rdy_r <= 1'b0;
    end
    else if (phase_r == CSU_IDLE && start)
    begin
      sel_up_r <= hit_up;
      sel_lo_r <= hit_lo;
      sel_mid_r <= hit_mid ? 4'(1 << mid_idx) : 4'h0;
      sel_per_r <= hit_per ? 7'(1 << per_idx) : 7'h00;
      a21_r <= addr[2:1];
      iram_r <= hit_iram;
      pcb_r <= hit_pcb;
      need_rdy_r <= mer_ready;
    end
    else if (phase_r == CSU_T4)
    begin
      // Drop selects, hits and ready demand once the cycle ends; A2:A1 is kept
      sel_up_r <= 1'b0;
      sel_lo_r <= 1'b0;
      sel_mid_r <= 4'h0;
      sel_per_r <= 7'h00;
      iram_r <= 1'b0;
      pcb_r <= 1'b0;
      need_rdy_r <= 1'b0;
    end
  end

  // Wait counter loaded at start, spent in the wait phase
  always_ff @(posedge clk)
  begin
    if (srst)
      wcnt_r <= 4'h0;
    else if (phase_r == CSU_IDLE && start)
      wcnt_r <= mer_wait;
    else if (phase_r == CSU_TW && wsub_r == CSU_W_PROG && wcnt_r != 4'h0)
      wcnt_r <= wcnt_r - 4'h1;
  end

  // Bus phase sequencer
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      phase_r <= CSU_IDLE;
      wsub_r <= CSU_W_PROG;
      first_w_r <= 1'b0;
      rdy_seen_r <= 1'b0;
    end
    else
    begin
      unique case (phase_r)
        CSU_IDLE:
          if (start)
            phase_r <= CSU_T1;
        CSU_T1:
          phase_r <= CSU_T2;
        CSU_T2:
          phase_r <= CSU_T3;
        CSU_T3:
        begin
          first_w_r <= 1'b1;
          rdy_seen_r <= 1'b0;
          if (wcnt_r != 4'h0)
          begin
            phase_r <= CSU_TW;
            wsub_r <= CSU_W_PROG;
          end
          else if (!need_rdy_r || ready_ok)
            phase_r <= CSU_T4;
          else
          begin
            phase_r <= CSU_TW;
            wsub_r <= CSU_W_HOLD;
          end
        end
        CSU_TW:
        begin
          first_w_r <= 1'b0;
          unique case (wsub_r)
            CSU_W_PROG:
            begin
              // Ready is judged only in the first wait cycle
              if (first_w_r)
                rdy_seen_r <= ready_ok;
              if (wcnt_r == 4'h1)
              begin
                if (!need_rdy_r || (first_w_r ? ready_ok : rdy_seen_r))
                  phase_r <= CSU_T4;
                else
                  wsub_r <= CSU_W_HOLD;
              end
            end
            CSU_W_HOLD:
              if (ready_ok)
                wsub_r <= CSU_W_EXTRA;
            CSU_W_EXTRA:
              phase_r <= CSU_T4;
            default:
              wsub_r <= CSU_W_PROG;
          endcase
        end
        CSU_T4:
          phase_r <= CSU_IDLE;
        default:
          phase_r <= CSU_IDLE;
      endcase
    end
  end

  // Pin drive; latched-address mode puts A2:A1 on upper slots
  always_comb
  begin
    upper_mem_select_n = ~sel_up_r;
    lower_mem_select_n = ~sel_lo_r;
    midrange_selects_n = ~sel_mid_r;
    lower_periph_selects_n = ~sel_per_r[3:0];
    upper_periph_selects_n = ms_latch_r ? a21_r : ~sel_per_r[6:5];
  end

  // Address bus stays quiet in T1 when upper/lower DA is set
  assign address_drive_disable = (phase_r == CSU_T1)
    && ((sel_up_r && up_da_r) || (sel_lo_r && lo_da_r));
  assign latched_addr_bits = a21_r;
  assign iram_hit = iram_r;
  assign pcb_hit = pcb_r;
  assign bus_phase = phase_r;
  assign waiting_ready = (phase_r == CSU_TW) && (wsub_r == CSU_W_HOLD);
  assign cycle_done = (phase_r == CSU_T4);

endmodule : csu_chip_select
`default_nettype wire

//--- test/csu_checker.sv
// Purpose: Port-level timing checks for the chip-select unit
// Assumes: One clock, srst synchronous and active high
// Notes: Bound onto the unit; watches only its ports
`timescale 1ns/1ps
`default_nettype none
module csu_checker
  import csu_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic cpu_cycle_start,
  input wire logic dma_cycle_start,
  input wire logic upper_mem_select_n,
  input wire logic lower_mem_select_n,
  input wire logic [3:0] midrange_selects_n,
  input wire logic [1:0] upper_periph_selects_n,
  input wire logic [3:0] lower_periph_selects_n,
  input wire logic [1:0] latched_addr_bits, // A2:A1, also on upper pins
  input wire logic address_drive_disable,
  input wire logic iram_hit,
  input wire logic pcb_hit,
  input wire csu_pkg::csu_phase_t bus_phase,
  input wire logic waiting_ready,
  input wire logic cycle_done
);
  import csu_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [11:0] sel_n; // All select pins in one word
  assign sel_n = {upper_mem_select_n, lower_mem_select_n,
    midrange_selects_n, upper_periph_selects_n, lower_periph_selects_n};
  // Fixed front of every access
  sequence s_front;
    bus_phase == CSU_T2 ##1 bus_phase == CSU_T3;
  endsequence
  // Extra wait after a late ready, then the last state
  sequence s_tail;
    bus_phase == CSU_TW ##1 bus_phase == CSU_T4;
  endsequence
  AST_START_T1:
    assert property ((cpu_cycle_start || dma_cycle_start)
      && bus_phase == CSU_IDLE |=> bus_phase == CSU_T1)
    else $error("Start not followed by T1");
  AST_FRONT:
    assert property (bus_phase == CSU_T1 |=> s_front)
    else $error("T1 not followed by T2 and T3");
  AST_AFTER_T3:
    assert property (bus_phase == CSU_T3 |=>
      bus_phase inside {CSU_TW, CSU_T4})
    else $error("Bad state after T3");
  AST_DONE_PULSE:
    assert property (cycle_done |->
      bus_phase == CSU_T4 ##1 (!cycle_done && bus_phase == CSU_IDLE))
    else $error("Done not a single T4 pulse");
  AST_LATE_EXTRA:
    assert property ($fell(waiting_ready) |-> s_tail)
    else $error("No single extra wait after ready");
  AST_WAIT_IN_TW:
    assert property (waiting_ready |-> bus_phase == CSU_TW)
    else $error("Ready wait outside wait state");
  // Upper peripheral pins keep showing A2:A1 in latched mode
  AST_IDLE_QUIET:
    assert property (bus_phase == CSU_IDLE |-> sel_n[11:6] == 6'h3f
      && lower_periph_selects_n == 4'hf && !iram_hit && !pcb_hit
      && (upper_periph_selects_n == 2'h3
      || upper_periph_selects_n == latched_addr_bits))
    else $error("Select active while idle");
  AST_SEL_HOLD:
    assert property (bus_phase != CSU_IDLE
      && $past(bus_phase) != CSU_IDLE |-> $stable(sel_n))
    else $error("Select changed inside a cycle");
  AST_DA_T1:
    assert property (address_drive_disable |-> bus_phase == CSU_T1
      && !(upper_mem_select_n && lower_mem_select_n))
    else $error("Address disable out of place");
  AST_IRAM_ZERO:
    assert property (iram_hit && bus_phase == CSU_T3 |=>
      bus_phase == CSU_T4)
    else $error("Internal RAM cycle got waits");
endmodule : csu_checker
bind csu_chip_select csu_checker CHK (.clk, .srst, .cpu_cycle_start,
  .dma_cycle_start, .upper_mem_select_n, .lower_mem_select_n,
  .midrange_selects_n, .upper_periph_selects_n, .lower_periph_selects_n,
  .latched_addr_bits, .address_drive_disable, .iram_hit, .pcb_hit,
  .bus_phase, .waiting_ready, .cycle_done);
`default_nettype wire

//--- test/csu_ready_model.sv
// Purpose: Far-side device that answers selects with ready
// Assumes: Ready line is low whenever the device is not selected
// Notes: Delay counts cycles from the first select cycle
`timescale 1ns/1ps
`default_nettype none
module csu_ready_model
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [11:0] sel_n,
  input wire logic [7:0] delay,
  input wire logic use_sync,
  output logic async_ready_input,
  output logic sync_ready_input
);
  logic [7:0] cnt_r; // Cycles spent selected
  logic rdy; // Device has its data
  // Count while selected; saturates so long stalls stay ready
  always_ff @(posedge clk)
  begin
    if (srst || &sel_n)
      cnt_r <= 8'h00;
    else if (cnt_r != 8'hff)
      cnt_r <= cnt_r + 8'h01;
  end
  // Released line drops rather than holding its last level
  assign rdy = !(&sel_n) && cnt_r >= delay;
  assign async_ready_input = rdy && !use_sync;
  assign sync_ready_input = rdy && use_sync;
endmodule : csu_ready_model
`default_nettype wire

//--- test/chip_select_ready_wait_logic_test.sv
// Purpose: Self-checking bench for the chip-select unit
// Assumes: Regions kept apart, so no overlap merging is exercised
// Notes: Cycle length counted from T1 to T4 at falling edges
`timescale 1ns/1ps
`default_nettype none
module chip_select_ready_wait_logic_test;
  import csu_pkg::*;
  logic clk, srst, cpu_cycle_start, cpu_is_io, dma_cycle_start, dma_is_io;
  logic [19:0] cpu_addr, dma_addr;
  logic async_ready_input, sync_ready_input, upper_cfg_load;
  logic upper_cfg_ready, upper_cfg_da, lower_cfg_load, lower_cfg_ready;
  logic lower_cfg_da, mid_cfg_load, mid_cfg_ready, pbase_cfg_load;
  logic pbase_cfg_ready, msize_cfg_load, msize_cfg_io, msize_cfg_ready;
  logic msize_cfg_latch_addr, iram_enable, pcb_in_mem;
  logic [9:0] upper_cfg_base, lower_cfg_top;
  logic [1:0] upper_cfg_wait, lower_cfg_wait, mid_cfg_wait, msize_cfg_wait;
  logic [6:0] mid_cfg_base;
  logic [8:0] pbase_cfg_base;
  logic [2:0] pbase_cfg_wait, msize_cfg_code;
  logic [4:0] iram_base;
  logic [11:0] pcb_base, sel_n, sel_g;
  logic upper_mem_select_n, lower_mem_select_n, address_drive_disable;
  logic iram_hit, pcb_hit, waiting_ready, cycle_done, use_sync;
  logic wait_g, da_g, hit_g;
  logic [3:0] midrange_selects_n, lower_periph_selects_n;
  logic [1:0] upper_periph_selects_n, latched_addr_bits, lat_g;
  logic [7:0] delay; // Far-side ready delay
  csu_phase_t bus_phase;
  int fails, check_count, cyc, len_g, done_g;
  csu_chip_select DUT (.clk, .srst, .cpu_cycle_start, .cpu_addr,
    .cpu_is_io, .dma_cycle_start, .dma_addr, .dma_is_io,
    .async_ready_input, .sync_ready_input, .upper_cfg_load,
    .upper_cfg_base, .upper_cfg_ready, .upper_cfg_wait, .upper_cfg_da,
    .lower_cfg_load, .lower_cfg_top, .lower_cfg_ready, .lower_cfg_wait,
    .lower_cfg_da, .mid_cfg_load, .mid_cfg_base, .mid_cfg_ready,
    .mid_cfg_wait, .pbase_cfg_load, .pbase_cfg_base, .pbase_cfg_ready,
    .pbase_cfg_wait, .msize_cfg_load, .msize_cfg_code, .msize_cfg_io,
    .msize_cfg_latch_addr, .msize_cfg_ready, .msize_cfg_wait,
    .iram_enable, .iram_base, .pcb_base, .pcb_in_mem,
    .upper_mem_select_n, .lower_mem_select_n, .midrange_selects_n,
    .upper_periph_selects_n, .lower_periph_selects_n, .latched_addr_bits,
    .address_drive_disable, .iram_hit, .pcb_hit, .bus_phase,
    .waiting_ready, .cycle_done);
  csu_ready_model PARTNER (.clk, .srst, .sel_n, .delay, .use_sync,
    .async_ready_input, .sync_ready_input);
  assign sel_n = {upper_mem_select_n, lower_mem_select_n,
    midrange_selects_n, upper_periph_selects_n, lower_periph_selects_n};
  always #5 clk = ~clk;
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
      fails++;
      close_out;
    end
  end
  task automatic close_out;
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Load every config word in one strobe cycle
  task automatic cfg;
    @(negedge clk);
    {upper_cfg_load, lower_cfg_load, mid_cfg_load, pbase_cfg_load,
      msize_cfg_load} = 5'h1f;
    @(negedge clk);
    {upper_cfg_load, lower_cfg_load, mid_cfg_load, pbase_cfg_load,
      msize_cfg_load} = 5'h00;
  endtask : cfg
  // One bus cycle; DMA runs give the CPU a different address
  task automatic run(input logic dma, input logic [19:0] a, input logic io);
    int n;
    @(negedge clk);
    cpu_cycle_start = !dma;
    dma_cycle_start = dma;
    cpu_addr = dma ? ~a : a;
    dma_addr = a;
    cpu_is_io = io;
    dma_is_io = io;
    @(negedge clk);
    cpu_cycle_start = 1'b0;
    dma_cycle_start = 1'b0;
    n = 0;
    while (bus_phase === CSU_IDLE && n < 4)
    begin
      n++;
      @(negedge clk);
    end
    sel_g = sel_n;
    lat_g = latched_addr_bits;
    da_g = address_drive_disable;
    hit_g = iram_hit | pcb_hit;
    wait_g = 1'b0;
    len_g = 0;
    done_g = 0;
    while (bus_phase !== CSU_IDLE && len_g < 60)
    begin
      wait_g = wait_g | waiting_ready;
      done_g = done_g + cycle_done;
      len_g++;
      @(negedge clk);
    end
  endtask : run
  task automatic go(input logic dma, input logic [19:0] a, input logic io,
    input int len, input logic [11:0] sel);
    run(dma, a, io);
    check(len_g, len);
    check(sel_g, sel);
    check(done_g, 1);
  endtask : go
  task automatic t_reset;
    check(sel_n, 12'hfff);
    go(0, 20'hf_fff0, 0, 7, 12'h7ff);
    go(0, 20'he_ffff, 0, 4, 12'hfff);
    go(0, 20'hf_0000, 1, 4, 12'hfff);
  endtask : t_reset
  // Every lower peripheral wait code, then other slots
  task automatic t_waits;
    int tbl [8] = '{0, 1, 2, 3, 5, 7, 9, 15};
    for (int c = 0; c < 8; c++)
    begin
      pbase_cfg_wait = 3'(c);
      cfg;
      go(0, 20'(256 * (c % 4)), 1, 4 + tbl[c],
        12'hfff & ~(12'h001 << (c % 4)));
    end
    go(0, 20'h0_0400, 1, 19, 12'hfff);
    go(0, 20'h0_0500, 1, 7, 12'hfef);
    go(0, 20'h2_0000, 0, 5, 12'hfbf);
    go(0, 20'h2_0800, 0, 5, 12'hf7f);
    go(0, 20'h0_0500, 0, 4, 12'hfff);
  endtask : t_waits
  task automatic t_space;
    go(0, 20'h0_0000, 0, 7, 12'hbff);
    go(0, 20'h0_0000, 1, 19, 12'hffe);
    go(0, 20'h0_8010, 0, 4, 12'hfff);
    check(hit_g, 1);
    go(0, 20'h0_ff00, 1, 4, 12'hfff);
    check(hit_g, 1);
  endtask : t_space
  task automatic t_ready;
    go(0, 20'hf_8000, 0, 6, 12'h7ff);
    check(da_g, 1);
    use_sync = 1'b1;
    go(0, 20'hf_8000, 0, 6, 12'h7ff);
    delay = 8'h0c;
    run(0, 20'hf_8000, 0);
    check(wait_g, 1);
    check(len_g > 7, 1);
    check(done_g, 1);
    delay = 8'h00;
    use_sync = 1'b0;
    go(1, 20'hf_8000, 0, 6, 12'h7ff);
  endtask : t_ready
  // Latched address mode drops the upper peripheral waits
  task automatic t_latch;
    msize_cfg_latch_addr = 1'b1;
    cfg;
    go(0, 20'h0_0506, 1, 4, 12'hfff);
    check(lat_g, 2'h3);
  endtask : t_latch
  initial
  begin
    {clk, cpu_cycle_start, cpu_is_io, dma_cycle_start, dma_is_io, cpu_addr,
      dma_addr, upper_cfg_load, upper_cfg_da, lower_cfg_load,
      lower_cfg_ready, lower_cfg_da, lower_cfg_top, mid_cfg_load,
      mid_cfg_ready, pbase_cfg_load, pbase_cfg_ready, pbase_cfg_base,
      pbase_cfg_wait, msize_cfg_load, msize_cfg_code, msize_cfg_latch_addr,
      msize_cfg_ready, iram_enable, pcb_in_mem, use_sync, delay} = '0;
    srst = 1'b1;
    fails = 0;
    check_count = 0;
    cyc = 0;
    // Disjoint regions, so overlap settings need not match
    upper_cfg_base = 10'h3c0;
    upper_cfg_ready = 1'b1;
    upper_cfg_wait = 2'h3;
    lower_cfg_wait = 2'h3;
    mid_cfg_base = 7'h10;
    mid_cfg_wait = 2'h1;
    msize_cfg_io = 1'b1;
    msize_cfg_wait = 2'h3;
    iram_base = 5'h01;
    pcb_base = 12'h0ff;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    t_reset;
    upper_cfg_wait = 2'h2;
    upper_cfg_da = 1'b1;
    iram_enable = 1'b1;
    t_waits;
    t_space;
    t_ready;
    t_latch;
    close_out;
  end
endmodule : chip_select_ready_wait_logic_test
`default_nettype wire
